// ---- hdl/ptpa_defs.vh ----
// Purpose: constants for the periodic tick and pulse accumulator block
// Assumes: 16-bit register address, 8-bit register data
// Notes: definitions only
`ifndef PTPA_DEFS_VH
`define PTPA_DEFS_VH

// register addresses
`define PTPA_ADDR_W 16
`define PTPA_CTRL_ADDR 16'h1026
`define PTPA_MASK_ADDR 16'h1030
`define PTPA_FLAG_ADDR 16'h1031
`define PTPA_COUNT_ADDR 16'h1032

// control register fields
`define PTPA_CTRL_PORTA7_DIR 7
`define PTPA_CTRL_ACC_EN 6
`define PTPA_CTRL_ACC_MODE 5
`define PTPA_CTRL_EDGE_SEL 4
`define PTPA_CTRL_PORTA3_DIR 3
`define PTPA_CTRL_CAP_CMP_SEL 2
`define PTPA_CTRL_RATE_HI 1
`define PTPA_CTRL_RATE_LO 0

// flag and mask register fields, same positions in both
`define PTPA_BIT_TIMER_OVF 7
`define PTPA_BIT_TICK 6
`define PTPA_BIT_ACC_OVF 5
`define PTPA_BIT_EDGE 4
`define PTPA_FLAG_IMPL 8'hF0

// reset values
`define PTPA_CTRL_RESET 8'h00
`define PTPA_MASK_RESET 8'h00
`define PTPA_FLAG_RESET 8'h00

// timing counts in bus clock cycles
`define PTPA_TICK_BASE_BITS 13
`define PTPA_TICK_BASE_DIV 8192
`define PTPA_TICK_EXTRA_BITS 3
`define PTPA_GATE_DIV_BITS 6
`define PTPA_GATE_DIV 64

`endif

// ---- hdl/ptpa_top.v ----
// Purpose: periodic tick generator and 8-bit pulse accumulator with flag/mask registers
// Assumes: one 25 MHz clock ref_clk; pulse input is an asynchronous pin
// Notes: register port is address, write data, strobes, read data one cycle later
//
// What this block does
// - tick base is a free-running divide by 2^13 of the bus clock, prescaler-independent
// - two-bit rate field adds divide by 1, 2, 4 or 8
// - tick divider stops only on reset; period runs from previous timeout
// - every tick timeout sets tick flag; request raised while its enable is set
// - after reset a full tick period passes before the first tick flag
// - writing one to a flag bit clears it, writing zero leaves it
// - tick flag is bit 6 of flag register, cleared by writing bit 6 set
// - each mask bit enables the request of the flag in the same position
// - timer overflow flag sets when the 16-bit main counter wraps to zero
// - accumulator enable bit: 0 disables, 1 enables the pulse accumulator
// - accumulator mode bit: 0 event counting, 1 gated time accumulation
// - event mode counts falling edges when edge select is 0, rising when 1
// - gated mode counts at clock/64 while input active; edge select sets inhibit level
// - pulse count readable and writable any time and untouched by reset
// - count increments never collide with software reads
// - accumulator overflow flag sets on each FF to 00 wrap; cleared by bit 5
// - overflow enable only gates the request, never touches the flag
// - input edge flag sets on each selected edge while the accumulator is enabled; cleared by bit 4
// - input edge enable only gates the request, never touches the flag
// - capture/compare select: 0 enables compare five, 1 enables capture four
// - timer overflow enable raises request while overflow flag set
`timescale 1ns/10ps
`default_nettype none
`include "ptpa_defs.vh"

module ptpa_top (
   input wire ref_clk,
   input wire reset,
   input wire [15:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [7:0] reg_rdata,
   input wire pulse_input,
   input wire main_counter_wrap,
   output reg [7:4] irq_request,
   output reg irq_any,
   output reg compare5_enable,
   output reg capture4_enable,
   output reg port_a7_dir,
   output reg port_a3_dir,
   output reg periodic_tick
);

   // address match, used by both the write and the read decode
   function addr_hit;
      input [15:0] addr;
      input [15:0] target;
      begin
         addr_hit = (addr == target);
      end
   endfunction

   // register file state
   reg [7:0] tick_and_accumulator_control_reg;
   reg [7:0] timer_mask_second_reg;
   reg [7:0] timer_event_flags_second_reg;
   reg [7:0] timer_event_flags_second_next;
   reg [7:0] pulse_count_value_reg;
   reg [7:0] pulse_count_value_next;
   reg [7:0] rdata_next;

   // decoded writes
   wire wr_ctrl;
   wire wr_mask;
   wire wr_flag;
   wire wr_count;
   assign wr_ctrl = reg_write & addr_hit(reg_addr, `PTPA_CTRL_ADDR);
   assign wr_mask = reg_write & addr_hit(reg_addr, `PTPA_MASK_ADDR);
   assign wr_flag = reg_write & addr_hit(reg_addr, `PTPA_FLAG_ADDR);
   assign wr_count = reg_write & addr_hit(reg_addr, `PTPA_COUNT_ADDR);

   // control fields
   wire acc_enable;
   wire acc_mode;
   wire edge_select;
   wire [1:0] tick_rate_field;
   assign acc_enable = tick_and_accumulator_control_reg[`PTPA_CTRL_ACC_EN];
   assign acc_mode = tick_and_accumulator_control_reg[`PTPA_CTRL_ACC_MODE];
   assign edge_select = tick_and_accumulator_control_reg[`PTPA_CTRL_EDGE_SEL];
   assign tick_rate_field = tick_and_accumulator_control_reg[`PTPA_CTRL_RATE_HI:`PTPA_CTRL_RATE_LO];

   // control register, all eight bits stored
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tick_and_accumulator_control_reg <= `PTPA_CTRL_RESET;
      end else if (wr_ctrl) begin
         tick_and_accumulator_control_reg <= reg_wdata;
      end
   end

   // mask register, only the four upper enables exist
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         timer_mask_second_reg <= `PTPA_MASK_RESET;
      end else if (wr_mask) begin
         timer_mask_second_reg <= reg_wdata & `PTPA_FLAG_IMPL;
      end
   end

   // tick divider chain
   reg [`PTPA_TICK_BASE_BITS-1:0] tick_base_reg;
   reg [`PTPA_TICK_EXTRA_BITS-1:0] tick_extra_reg;
   wire tick_base_done;
   reg tick_rate_done;
   wire tick_timeout;

   assign tick_base_done = &tick_base_reg;

   // free running, no enable and no clear besides reset
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tick_base_reg <= {`PTPA_TICK_BASE_BITS{1'b0}};
         tick_extra_reg <= {`PTPA_TICK_EXTRA_BITS{1'b0}};
      end else begin
         tick_base_reg <= tick_base_reg + 1'b1;
         if (tick_base_done) begin
            tick_extra_reg <= tick_extra_reg + 1'b1;
         end
      end
   end

   // extra division selected by the rate field
   always @* begin
      case (tick_rate_field)
         2'b00: tick_rate_done = 1'b1;
         2'b01: tick_rate_done = tick_extra_reg[0];
         2'b10: tick_rate_done = &tick_extra_reg[1:0];
         2'b11: tick_rate_done = &tick_extra_reg[2:0];
         default: tick_rate_done = 1'b1;
      endcase
   end

   // both counters start at zero, so the first timeout ends a full period
   assign tick_timeout = tick_base_done & tick_rate_done;

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         periodic_tick <= 1'b0;
      end else begin
         periodic_tick <= tick_timeout;
      end
   end

   // gated mode time base, free running like the tick divider
   reg [`PTPA_GATE_DIV_BITS-1:0] gate_div_reg;
   wire gate_div_done;
   assign gate_div_done = &gate_div_reg;

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         gate_div_reg <= {`PTPA_GATE_DIV_BITS{1'b0}};
      end else begin
         gate_div_reg <= gate_div_reg + 1'b1;
      end
   end

   // pulse pin synchroniser and agreement filter
   reg pin_sync1_reg;
   reg pin_sync2_reg;
   reg pin_sync3_reg;
   reg pin_level_reg;
   reg pin_level_next;
   wire pin_rise;
   wire pin_fall;

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pin_sync1_reg <= 1'b0;
         pin_sync2_reg <= 1'b0;
         pin_sync3_reg <= 1'b0;
      end else begin
         pin_sync1_reg <= pulse_input;
         pin_sync2_reg <= pin_sync1_reg;
         pin_sync3_reg <= pin_sync2_reg;
      end
   end

   // a level counts only once the last two stages agree
   always @* begin
      pin_level_next = pin_level_reg;
      if (pin_sync2_reg == pin_sync3_reg) begin
         pin_level_next = pin_sync3_reg;
      end
   end

   // edges masked until the chain holds fresh samples, so a pin high at reset gives no false rise
   reg [1:0] pin_fill_reg;
   reg pin_primed_reg;
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pin_level_reg <= 1'b0;
         pin_fill_reg <= 2'b00;
         pin_primed_reg <= 1'b0;
      end else begin
         pin_level_reg <= pin_level_next;
         if (pin_fill_reg != 2'b11) begin
            pin_fill_reg <= pin_fill_reg + 2'b01;
         end
         pin_primed_reg <= (pin_fill_reg == 2'b11);
      end
   end

   // the filter delays edges but cannot merge two if the source keeps to half rate
   assign pin_rise = pin_primed_reg & pin_level_next & ~pin_level_reg;
   assign pin_fall = pin_primed_reg & ~pin_level_next & pin_level_reg;

   // selected edge: falling for select 0, rising for select 1
   wire selected_edge;
   assign selected_edge = edge_select ? pin_rise : pin_fall;

   // gate is active when the input is not at its inhibiting level
   wire gate_active;
   assign gate_active = edge_select ? ~pin_level_reg : pin_level_reg;

   // increment request from either mode
   reg count_step;
   always @* begin
      count_step = 1'b0;
      if (acc_enable) begin
         if (acc_mode) begin
            count_step = gate_active & gate_div_done;
         end else begin
            count_step = selected_edge;
         end
      end
   end

   wire count_wrap;
   assign count_wrap = count_step & ~wr_count & (&pulse_count_value_reg);

   // software write wins over an increment in the same cycle
   always @* begin
      pulse_count_value_next = pulse_count_value_reg;
      if (wr_count) begin
         pulse_count_value_next = reg_wdata;
      end else if (count_step) begin
         pulse_count_value_next = pulse_count_value_reg + 8'h01;
      end
   end

   // deliberately outside the reset so the count survives it
   always @(posedge ref_clk) begin
      pulse_count_value_reg <= pulse_count_value_next;
   end

   // edge flag source; in gated mode the same edge closes an active interval
   wire edge_event;
   assign edge_event = acc_enable & selected_edge;

   // flag register: set beats clear in the same cycle
   reg [7:0] flag_set;
   reg [7:0] flag_clear;
   always @* begin
      flag_set = 8'h00;
      flag_set[`PTPA_BIT_TIMER_OVF] = main_counter_wrap;
      flag_set[`PTPA_BIT_TICK] = tick_timeout;
      flag_set[`PTPA_BIT_ACC_OVF] = count_wrap;
      flag_set[`PTPA_BIT_EDGE] = edge_event;
      flag_clear = 8'h00;
      if (wr_flag) begin
         flag_clear = reg_wdata & `PTPA_FLAG_IMPL;
      end
      timer_event_flags_second_next =
         ((timer_event_flags_second_reg & ~flag_clear) | flag_set) & `PTPA_FLAG_IMPL;
   end

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         timer_event_flags_second_reg <= `PTPA_FLAG_RESET;
      end else begin
         timer_event_flags_second_reg <= timer_event_flags_second_next;
      end
   end

   // requests use the enables only as a gate; flags never see them
   wire [7:4] request_next;
   genvar gi;
   generate
      for (gi = 4; gi < 8; gi = gi + 1) begin : g_req
         assign request_next[gi] = timer_event_flags_second_reg[gi] & timer_mask_second_reg[gi];
      end
   endgenerate

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         irq_request <= 4'h0;
         irq_any <= 1'b0;
      end else begin
         irq_request <= request_next;
         irq_any <= |request_next;
      end
   end

   // capture/compare select and port A direction bits leave as plain levels
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         compare5_enable <= 1'b1;
         capture4_enable <= 1'b0;
         port_a7_dir <= 1'b0;
         port_a3_dir <= 1'b0;
      end else begin
         compare5_enable <= ~tick_and_accumulator_control_reg[`PTPA_CTRL_CAP_CMP_SEL];
         capture4_enable <= tick_and_accumulator_control_reg[`PTPA_CTRL_CAP_CMP_SEL];
         port_a7_dir <= tick_and_accumulator_control_reg[`PTPA_CTRL_PORTA7_DIR];
         port_a3_dir <= tick_and_accumulator_control_reg[`PTPA_CTRL_PORTA3_DIR];
      end
   end

   // read mux samples registered values, so an increment in the same cycle cannot tear a read
   always @* begin
      rdata_next = 8'h00;
      if (reg_read) begin
         if (addr_hit(reg_addr, `PTPA_CTRL_ADDR)) begin
            rdata_next = tick_and_accumulator_control_reg;
         end else if (addr_hit(reg_addr, `PTPA_MASK_ADDR)) begin
            rdata_next = timer_mask_second_reg;
         end else if (addr_hit(reg_addr, `PTPA_FLAG_ADDR)) begin
            rdata_next = timer_event_flags_second_reg & `PTPA_FLAG_IMPL;
         end else if (addr_hit(reg_addr, `PTPA_COUNT_ADDR)) begin
            rdata_next = pulse_count_value_reg;
         end
      end
   end

   // read data stand for one cycle only, zero otherwise
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= rdata_next;
      end
   end

endmodule // ptpa_top

`default_nettype wire

// ---- dv/ptpa_asserts.sv ----
// Purpose: port-level checks for ptpa_top
// Assumes: register map and bit positions of ptpa_defs.vh
// Notes: mask shadow is rebuilt from bus writes, so it lags like the real one
`timescale 1ns/10ps
`default_nettype none
`include "ptpa_defs.vh"
module ptpa_asserts (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic pulse_input,
   input wire logic main_counter_wrap,
   input wire logic [7:4] irq_request,
   input wire logic irq_any,
   input wire logic compare5_enable,
   input wire logic capture4_enable,
   input wire logic port_a7_dir,
   input wire logic port_a3_dir,
   input wire logic periodic_tick
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic [7:0] mask_reg;
   logic [16:0] gap_reg;
   logic seen_reg;
   logic [1:0] rate_reg;
   logic steady_reg;
   logic ctrl_wr_prev_reg;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mask_reg <= 8'h00;
         gap_reg <= 17'h0_0000;
         seen_reg <= 1'b0;
         rate_reg <= 2'b00;
         steady_reg <= 1'b0;
         ctrl_wr_prev_reg <= 1'b0;
      end else begin
         if (reg_write && reg_addr == `PTPA_MASK_ADDR) mask_reg <= reg_wdata;
         // a rate change may shorten the next gap, so only a tick seen at the same rate arms the check
         ctrl_wr_prev_reg <= reg_write && reg_addr == `PTPA_CTRL_ADDR;
         if (reg_write && reg_addr == `PTPA_CTRL_ADDR) begin
            rate_reg <= reg_wdata[1:0];
            steady_reg <= 1'b0;
         end else if (periodic_tick && !ctrl_wr_prev_reg) begin
            steady_reg <= 1'b1;
         end
         gap_reg <= periodic_tick ? 17'h0_0001 : gap_reg + 17'h0_0001;
         if (periodic_tick) seen_reg <= 1'b1;
      end
   end
   chk_tick_one_cycle: assert property (periodic_tick |=> !periodic_tick)
      else $error("tick pulse longer than one cycle");
   // gap counter: any rate is a whole number of base periods
   chk_tick_gap: assert property (periodic_tick && seen_reg |-> gap_reg[12:0] == 13'h0000 && gap_reg != 17'h0_0000)
      else $error("tick spacing not a multiple of the base period");
   chk_tick_first: assert property (!seen_reg && gap_reg < 17'h0_2000 |-> !periodic_tick)
      else $error("first tick too early after reset");
   chk_tick_rate: assert property (periodic_tick && steady_reg |-> gap_reg == (17'h0_2000 << rate_reg))
      else $error("tick spacing does not match the rate field");
   chk_compare_excl: assert property (compare5_enable != capture4_enable)
      else $error("compare and capture enables not exclusive");
   chk_mask_gates: assert property ((irq_request & ~$past(mask_reg[7:4])) == 4'h0)
      else $error("request raised with its enable clear");
   chk_ovf_request: assert property (main_counter_wrap && mask_reg[7] && !(reg_write && reg_addr == `PTPA_MASK_ADDR)
      |-> ##2 irq_request[7])
      else $error("counter wrap gave no overflow request");
   chk_ovf_clear: assert property (reg_write && reg_addr == `PTPA_FLAG_ADDR && reg_wdata[7] && !main_counter_wrap
      |-> ##2 !irq_request[7])
      else $error("overflow request survived its clear");
   chk_any_follows: assert property (irq_any == (|irq_request))
      else $error("combined request missing");
   chk_flag_low_zero: assert property ($past(reg_read && reg_addr == `PTPA_FLAG_ADDR) |-> reg_rdata[3:0] == 4'h0)
      else $error("unimplemented flag bits read nonzero");
   cover property (periodic_tick && seen_reg);
   cover property (main_counter_wrap && mask_reg[7]);
   cover property (irq_request[5] && irq_request[4]);
endmodule // ptpa_asserts
`default_nettype wire

// ---- dv/ptpa_pulse_src.sv ----
// Purpose: source for the pulse input pin
// Assumes: driven from the bench clock
// Notes: levels last whole cycles; a driven pin, so no float
`timescale 1ns/10ps
`default_nettype none
module ptpa_pulse_src (
   input wire logic ref_clk,
   output logic pin
);
   initial pin = 1'b0;
   // callers keep n at 2 or more, so edges never beat clock/2
   task automatic hold(input logic v, input int n);
      @(posedge ref_clk);
      pin <= v;
      repeat (n - 1) @(posedge ref_clk);
   endtask
   task automatic pulses(input int k);
      repeat (k) begin
         hold(1'b1, 4);
         hold(1'b0, 4);
      end
   endtask
endmodule // ptpa_pulse_src
`default_nettype wire

// ---- dv/ptpa_tb_top.sv ----
// Purpose: self-checking bench for ptpa_top
// Assumes: 25 MHz ref_clk, register map of ptpa_defs.vh
// Notes: tick periods make the run about 49k cycles
`timescale 1ns/10ps
`default_nettype none
`include "ptpa_defs.vh"
module ptpa_tb_top;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic main_counter_wrap = 1'b0;
   logic [7:0] d;
   wire [7:0] reg_rdata;
   wire [7:4] irq_request;
   wire irq_any;
   wire periodic_tick;
   wire pulse_input;
   wire cmp5_en;
   wire cap4_en;
   wire dir_a7;
   wire dir_a3;
   int fails = 0;
   int n_compared = 0;
   int cyc = 0;
   int c0;
   always #20 ref_clk = ~ref_clk;
   ptpa_top ptpa_top_inst (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pulse_input(pulse_input),
      .main_counter_wrap(main_counter_wrap), .irq_request(irq_request), .irq_any(irq_any),
      .compare5_enable(cmp5_en), .capture4_enable(cap4_en), .port_a7_dir(dir_a7), .port_a3_dir(dir_a3),
      .periodic_tick(periodic_tick));
   ptpa_pulse_src ptpa_pulse_src_inst (.ref_clk(ref_clk), .pin(pulse_input));
   task automatic close_out;
      if (fails == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rc(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
      chk(d & m, e);
   endtask
   task automatic wait_tick;
      do begin
         @(posedge ref_clk);
         #1;
      end while (periodic_tick !== 1'b1);
   endtask
   // hang guard well above the slowest tick wait
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         fails++;
         close_out;
      end
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      c0 = cyc;
      rc(`PTPA_CTRL_ADDR, 8'hFF, `PTPA_CTRL_RESET);
      rc(`PTPA_FLAG_ADDR, 8'hFF, 8'h00);
      rc(16'h1027, 8'hFF, 8'h00);
      wr(`PTPA_MASK_ADDR, 8'hFF);
      rc(`PTPA_MASK_ADDR, 8'hFF, 8'hF0);
      wr(`PTPA_MASK_ADDR, 8'h80);
      @(posedge ref_clk) main_counter_wrap <= 1'b1;
      @(posedge ref_clk) main_counter_wrap <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 chk(irq_request, 4'h8);
      chk(irq_any, 1'b1);
      wr(`PTPA_FLAG_ADDR, 8'h00);
      rc(`PTPA_FLAG_ADDR, 8'hBF, 8'h80);
      wr(`PTPA_FLAG_ADDR, 8'h80);
      rc(`PTPA_FLAG_ADDR, 8'hBF, 8'h00);
      wr(`PTPA_MASK_ADDR, 8'h30);
      // each pulse has one edge of each kind, so either edge select adds one per pulse
      for (int e = 0; e < 2; e++) begin
         wr(`PTPA_CTRL_ADDR, e ? 8'h50 : 8'h40);
         wr(`PTPA_COUNT_ADDR, 8'hFE);
         wr(`PTPA_FLAG_ADDR, 8'hF0);
         ptpa_pulse_src_inst.pulses(1);
         repeat (6) @(posedge ref_clk);
         rc(`PTPA_COUNT_ADDR, 8'hFF, 8'hFF);
         ptpa_pulse_src_inst.pulses(1);
         repeat (6) @(posedge ref_clk);
         rc(`PTPA_COUNT_ADDR, 8'hFF, 8'h00);
         rc(`PTPA_FLAG_ADDR, 8'hBF, 8'h30);
         chk(irq_request[5:4], 2'h3);
         wr(`PTPA_FLAG_ADDR, 8'h20);
         rc(`PTPA_FLAG_ADDR, 8'hBF, 8'h10);
      end
      wr(`PTPA_CTRL_ADDR, 8'h10);
      wr(`PTPA_COUNT_ADDR, 8'h05);
      wr(`PTPA_FLAG_ADDR, 8'hF0);
      ptpa_pulse_src_inst.pulses(2);
      repeat (6) @(posedge ref_clk);
      rc(`PTPA_COUNT_ADDR, 8'hFF, 8'h05);
      rc(`PTPA_FLAG_ADDR, 8'hBF, 8'h00);
      // 640 active cycles hold exactly ten divide-by-64 steps
      wr(`PTPA_CTRL_ADDR, 8'h60);
      wr(`PTPA_COUNT_ADDR, 8'h00);
      ptpa_pulse_src_inst.hold(1'b1, 640);
      ptpa_pulse_src_inst.hold(1'b0, 640);
      rc(`PTPA_COUNT_ADDR, 8'hFF, 8'h0A);
      rc(`PTPA_FLAG_ADDR, 8'hBF, 8'h10);
      wr(`PTPA_CTRL_ADDR, 8'h8C);
      @(posedge ref_clk);
      #1 chk({cmp5_en, cap4_en, dir_a7, dir_a3}, 4'h7);
      wr(`PTPA_MASK_ADDR, 8'h40);
      wr(`PTPA_CTRL_ADDR, 8'h00);
      @(posedge ref_clk);
      #1 chk({cmp5_en, cap4_en, dir_a7, dir_a3}, 4'h8);
      wait_tick;
      chk(cyc - c0 >= 8190 && cyc - c0 <= 8196, 1);
      repeat (2) @(posedge ref_clk);
      #1 chk(irq_request, 4'h4);
      rc(`PTPA_FLAG_ADDR, 8'h40, 8'h40);
      wr(`PTPA_FLAG_ADDR, 8'h40);
      rc(`PTPA_FLAG_ADDR, 8'h40, 8'h00);
      // first gap after a rate change may be short, so time the second
      for (int r = 0; r < 4; r++) begin
         wr(`PTPA_CTRL_ADDR, r[7:0]);
         rc(`PTPA_CTRL_ADDR, 8'hFF, r[7:0]);
         if (r < 2) begin
            wait_tick;
            c0 = cyc;
            wait_tick;
            chk(cyc - c0, 8192 << r);
         end
      end
      wr(`PTPA_COUNT_ADDR, 8'h5A);
      @(posedge ref_clk) reset <= 1'b1;
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      rc(`PTPA_COUNT_ADDR, 8'hFF, 8'h5A);
      rc(`PTPA_CTRL_ADDR, 8'hFF, 8'h00);
      close_out;
   end
endmodule // ptpa_tb_top
bind ptpa_top ptpa_asserts ptpa_asserts_inst (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .pulse_input(pulse_input), .main_counter_wrap(main_counter_wrap), .irq_request(irq_request),
   .irq_any(irq_any), .compare5_enable(compare5_enable), .capture4_enable(capture4_enable),
   .port_a7_dir(port_a7_dir), .port_a3_dir(port_a3_dir), .periodic_tick(periodic_tick));
`default_nettype wire
